/* rtl/dmaie_defs.svh */
`ifndef DMAIE_DEFS_SVH
`define DMAIE_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define DMAIE_OFS_MASK 8'h34
`define DMAIE_OFS_STATUS 8'h38
`define DMAIE_OFS_FLAG 8'h3c

// ----------------------------------------------------------------
// Field positions of the enable, status and flag words
// ----------------------------------------------------------------
`define DMAIE_BIT_LINKEND_TEST 0
`define DMAIE_BIT_CHAINEND_TEST 1
`define DMAIE_BIT_DESC_FINISH 2
`define DMAIE_BIT_LIST_FINISH 3
`define DMAIE_BIT_DESC_BEGIN 4
`define DMAIE_BIT_AWAIT_ADV 5
`define DMAIE_BIT_ABORT_DONE 6
`define DMAIE_BIT_FIFO_AFULL 8
`define DMAIE_BIT_WRITES_DONE 9
`define DMAIE_BIT_PKT_END 10

// ----------------------------------------------------------------
// Implemented bits and reset values
// ----------------------------------------------------------------
`define DMAIE_MASK_RW 11'h77f
`define DMAIE_SRC_BITS 11'h77c
`define DMAIE_MASK_RESET 11'h000
`define DMAIE_FLAG_RESET 11'h000

`endif

/* rtl/dmaie_pkg.sv */
package dmaie_pkg;

    // ------------------------------------------------------------
    // Shared types
    // ------------------------------------------------------------
    typedef logic [10:0] dmaie_bits_t;

    // Source condition levels from the DMA engine
    typedef struct packed {
        logic pkt_end;
        logic writes_done;
        logic fifo_afull;
        logic abort_done;
        logic await_adv;
        logic desc_begin;
        logic list_finish;
        logic list_finish_en;
        logic desc_finish;
        logic desc_finish_en;
    } dmaie_src_s;

    // Bus slave phase states
    typedef enum logic [0:0] {
        DMAIE_IDLE = 1'b0,
        DMAIE_DATA = 1'b1
    } dmaie_phase_e;

endpackage : dmaie_pkg

/* rtl/dmaie_edge.sv */
`include "dmaie_defs.svh"

module dmaie_edge
    import dmaie_pkg::*;
#(
    parameter int WIDTH = 11
) (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic [WIDTH-1:0] LEVEL,
    output logic [WIDTH-1:0] RISE
);

    initial begin
        if (WIDTH < 1) begin
            $error("dmaie_edge: WIDTH must be at least 1");
        end
    end

    typedef struct packed {
        logic [WIDTH-1:0] prev;
    } dmaie_edge_s;

    dmaie_edge_s st_reg;
    dmaie_edge_s st_next;

    // Remember last level
    always_comb begin
        st_next = st_reg;
        st_next.prev = LEVEL;
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Low to high only; a held level gives one pulse
    assign RISE = LEVEL & ~st_reg.prev; // RULE1

endmodule : dmaie_edge

/* rtl/dmaie_top.sv */
// How it works
// RULE1: irq on rising edge of enabled status bit; held high gives no more
// RULE2: enable register at 0x34; bits 31:11 and 7 reserved
// RULE3: enable bits read/write, reset to 0; 1 enables, 0 disables
// RULE4: bit 10 gates end-of-packet source
// RULE5: bit 9 gates all-writes-complete source
// RULE6: bit 8 gates input FIFO almost full source
// RULE7: bit 6 gates abort complete source
// RULE8: bit 5 gates waiting-for-advance source
// RULE9: bit 4 gates descriptor begin source
// RULE10: bit 3 gates chain end, only when descriptor chain-end enable set
// RULE11: bit 2 gates descriptor finish, only when descriptor enable set
// RULE12: bits 1 and 0 are plain test bits, read/write, reset 0
// RULE13: status rising sets sticky flag until software clears it
// RULE14: status bit follows its condition, independent of flag
// RULE15: one interrupt output combines all enabled source events
//
// The AHB-Lite register port is this design's own decision.
`include "dmaie_defs.svh"

module dmaie_top
    import dmaie_pkg::*;
#(
    parameter int ADDR_WIDTH = 8
) (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic HSEL,
    input wire logic [ADDR_WIDTH-1:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic HREADY,
    input wire logic [31:0] HWDATA,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire dmaie_src_s SRC,
    output logic IRQ
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    initial begin
        if (ADDR_WIDTH < 8) begin
            $error("dmaie_top: ADDR_WIDTH must be at least 8");
        end
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        dmaie_phase_e phase;
        logic wr;
        logic [ADDR_WIDTH-1:0] addr;
        dmaie_bits_t mask;
        dmaie_bits_t flag;
        logic [31:0] rdata;
        logic irq;
    } dmaie_top_s;

    dmaie_top_s st_reg;
    dmaie_top_s st_next;

    dmaie_bits_t status;
    dmaie_bits_t rise;
    logic take;

    // ------------------------------------------------------------
    // Source status word
    // ------------------------------------------------------------
    // Status tracks conditions live, no latching
    always_comb begin
        status = '0;
        status[`DMAIE_BIT_PKT_END] = SRC.pkt_end; // RULE4 RULE14
        status[`DMAIE_BIT_WRITES_DONE] = SRC.writes_done; // RULE5
        status[`DMAIE_BIT_FIFO_AFULL] = SRC.fifo_afull; // RULE6
        status[`DMAIE_BIT_ABORT_DONE] = SRC.abort_done; // RULE7
        status[`DMAIE_BIT_AWAIT_ADV] = SRC.await_adv; // RULE8
        status[`DMAIE_BIT_DESC_BEGIN] = SRC.desc_begin; // RULE9
        status[`DMAIE_BIT_LIST_FINISH] =
            SRC.list_finish & SRC.list_finish_en; // RULE10
        status[`DMAIE_BIT_DESC_FINISH] =
            SRC.desc_finish & SRC.desc_finish_en; // RULE11
    end

    // Rising edge finder on every status bit
    dmaie_edge #(
        .WIDTH(11)
    ) u_edge (
        .CORE_CLK(CORE_CLK),
        .RESET_N(RESET_N),
        .LEVEL(status),
        .RISE(rise)
    );

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign take = HSEL & HREADY & HTRANS[1];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.rdata = 32'h0000_0000;
        case (st_reg.phase)
            DMAIE_IDLE: begin
            end
            DMAIE_DATA: begin
                if (st_reg.wr) begin
                    if (st_reg.addr == ADDR_WIDTH'(`DMAIE_OFS_MASK)) begin
                        // Reserved bit 7 stays zero
                        st_next.mask = HWDATA[10:0]
                            & `DMAIE_MASK_RW; // RULE3 RULE12
                    end else if (st_reg.addr
                        == ADDR_WIDTH'(`DMAIE_OFS_FLAG)) begin
                        // Write one to clear
                        st_next.flag = st_reg.flag & ~HWDATA[10:0];
                    end
                end
            end
            default: begin
            end
        endcase
        // New events win over a clear in the same cycle
        st_next.flag = st_next.flag
            | (rise & `DMAIE_SRC_BITS); // RULE13
        // Enabled edges only, merged onto one line
        st_next.irq = |(rise & st_reg.mask
            & `DMAIE_SRC_BITS); // RULE1 RULE15
        if (take) begin
            st_next.phase = DMAIE_DATA;
            st_next.wr = HWRITE;
            st_next.addr = HADDR;
        end else begin
            st_next.phase = DMAIE_IDLE;
            st_next.wr = 1'b0;
        end
        // Read word latched at the address phase, after any write lands
        if (take && !HWRITE) begin
            if (HADDR == ADDR_WIDTH'(`DMAIE_OFS_MASK)) begin
                st_next.rdata[10:0] = st_next.mask; // RULE2 RULE3
            end else if (HADDR == ADDR_WIDTH'(`DMAIE_OFS_STATUS)) begin
                st_next.rdata[10:0] = status; // RULE14
            end else if (HADDR == ADDR_WIDTH'(`DMAIE_OFS_FLAG)) begin
                st_next.rdata[10:0] = st_next.flag; // RULE13
            end
        end
    end

    // Read data captured for the data phase
    always_comb begin
        HRDATA = st_reg.rdata;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign IRQ = st_reg.irq;

endmodule : dmaie_top

/* dv/dmaie_top_assertions.sv */
module dmaie_chk
    import dmaie_pkg::*;
#(
    parameter int ADDR_WIDTH = 8
) (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic HSEL,
    input wire logic [ADDR_WIDTH-1:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic [31:0] HWDATA,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire dmaie_src_s SRC,
    input wire logic IRQ
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [10:0] st, st_q, msk;
    logic ev, wr_dp, rd_dp;
    logic [ADDR_WIDTH-1:0] adr;
    // Status word as the sources present it
    assign st = {SRC.pkt_end, SRC.writes_done, SRC.fifo_afull, 1'b0,
        SRC.abort_done, SRC.await_adv, SRC.desc_begin,
        SRC.list_finish & SRC.list_finish_en,
        SRC.desc_finish & SRC.desc_finish_en, 2'h0};
    assign ev = |(st & ~st_q & msk);
    // Shadow of mask and bus data phase
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            {st_q, msk, wr_dp, rd_dp, adr} <= '0;
        end else begin
            st_q <= st;
            if (wr_dp && adr == 8'h34) msk <= HWDATA[10:0] & 11'h77f;
            wr_dp <= HSEL && HREADY && HTRANS[1] && HWRITE;
            rd_dp <= HSEL && HREADY && HTRANS[1] && !HWRITE;
            adr <= HADDR;
        end
    end
    default clocking dc @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);
    sequence s_steady; $stable(st)[*3]; endsequence
    sequence s_stat_rd; $stable(st)[*4] ##0 rd_dp && adr == 8'h38; endsequence
    a_irq_on_rise: assert property (ev |-> ##[1:2] IRQ)
        else $error("irq missing");
    a_irq_has_cause: assert property (IRQ |-> $past(ev) || $past(ev, 2))
        else $error("irq without cause");
    a_steady_quiet: assert property (s_steady |-> !IRQ)
        else $error("irq on steady level");
    a_bus_okay: assert property (HREADYOUT && !HRESP)
        else $error("bad response");
    a_rsvd_zero: assert property (rd_dp |-> HRDATA[31:11] == 0 && !HRDATA[7])
        else $error("reserved bits set");
    a_mask_back: assert property (rd_dp && adr == 8'h34 |-> HRDATA[10:0] == msk)
        else $error("mask readback");
    a_unmapped_zero: assert property (rd_dp && !(adr inside {8'h34, 8'h38,
        8'h3c}) |-> HRDATA == 0)
        else $error("unmapped read");
    a_status_live: assert property (s_stat_rd |-> HRDATA[10:0] == st)
        else $error("status not live");
endmodule : dmaie_chk

bind dmaie_top dmaie_chk #(.ADDR_WIDTH(ADDR_WIDTH)) chk_u (
    .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HWDATA(HWDATA),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SRC(SRC),
    .IRQ(IRQ)
);

/* dv/tb.sv */
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
    n_mismatch++; $display("unexpected %0t: %h not %h", $time, g, e); end end

module tb;
    import dmaie_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic CORE_CLK = 0, RESET_N = 0, HSEL = 0, HWRITE = 0, rd_dp = 0;
    logic [7:0] HADDR = 0;
    logic [1:0] HTRANS = 0;
    logic [31:0] HWDATA = 0, HRDATA, ev;
    logic HREADYOUT, HRESP, IRQ, HREADY;
    dmaie_src_s SRC = '0;
    int n_mismatch = 0, total_checks = 0, n_irq = 0, cyc = 0;
    logic [31:0] rq[$];
    assign HREADY = HREADYOUT;
    dmaie_top dut_u (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
        .HREADY(HREADY), .HWDATA(HWDATA), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SRC(SRC), .IRQ(IRQ));
    initial begin
        forever #5 CORE_CLK = ~CORE_CLK;
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude
    // Read data check, pulse count and hang limit
    always @(posedge CORE_CLK) begin
        if (rd_dp) begin
            ev = rq.pop_front();
            `CHK(HRDATA, ev)
        end
        rd_dp = HSEL && HTRANS[1] && !HWRITE && HREADY;
        n_irq += int'(IRQ === 1'b1);
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            conclude();
        end
    end
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge CORE_CLK);
        HSEL <= 1'b1;
        HWRITE <= w;
        HADDR <= a;
        HTRANS <= 2'h2;
        do @(posedge CORE_CLK); while (HREADY !== 1'b1);
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge CORE_CLK); while (HREADY !== 1'b1);
    endtask : xfer
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        xfer(1'b0, a, 32'h0);
    endtask : rd
    function automatic logic [31:0] stat(input dmaie_src_s s);
        return {21'h0, s.pkt_end, s.writes_done, s.fifo_afull, 1'b0,
            s.abort_done, s.await_adv, s.desc_begin,
            s.list_finish & s.list_finish_en,
            s.desc_finish & s.desc_finish_en, 2'h0};
    endfunction : stat
    // Reset state, unmapped space, then random masks and sources
    initial begin
        dmaie_src_s s;
        logic [31:0] m;
        int n0;
        void'($urandom(1));
        repeat (8) @(posedge CORE_CLK);
        RESET_N <= 1'b1;
        rd(8'h34, 32'h0);
        rd(8'h38, 32'h0);
        rd(8'h3c, 32'h0);
        xfer(1'b1, 8'h40, $urandom);
        rd(8'h40, 32'h0);
        for (int i = 0; i < 24; i++) begin
            m = $urandom;
            s = dmaie_src_s'(10'($urandom));
            xfer(1'b1, 8'h34, m);
            rd(8'h34, m & 32'h77f);
            n0 = n_irq;
            SRC <= s;
            repeat (6) @(posedge CORE_CLK);
            `CHK(n_irq - n0, int'(|(stat(s) & m)))
            rd(8'h38, stat(s));
            SRC <= '0;
            repeat (4) @(posedge CORE_CLK);
            rd(8'h38, 32'h0);
            rd(8'h3c, stat(s));
            xfer(1'b1, 8'h3c, 32'h7ff);
            rd(8'h3c, 32'h0);
        end
        repeat (3) @(posedge CORE_CLK);
        conclude();
    end
endmodule : tb
